// ### verilog/swc_sleep_ctrl.sv
// sleep and wake controller: apb registers, sleep state machine
// assumes the core pulses sleep_exec once per sleep instruction
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "swc_map.svh"
module swc_sleep_ctrl
  import swc_pkg::*;
(
  // clock and reset (reset is the master clear pin, input only)
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core
  input wire logic sleep_exec,
  input wire logic wdog_clr_exec,
  output logic prefetch_req,
  output logic core_stall,
  output logic vector_req,
  output logic [12:0] vector_addr,
  // watchdog
  input wire logic wdog_timeout,
  output logic wdog_clear,
  // interrupt sources, pulses that set flags
  input wire logic [7:0] flg_one_set,
  input wire logic flg_two_set,
  input wire logic ext_edge_set,
  input wire logic port_change_set,
  // clocks and ports
  output logic osc_drv_en,
  output logic port_hold
);
  swc_state_e state_q;
  swc_byte_t ioc_q, intctl_q, en_one_q, en_two_q, flg_one_q, flg_two_q;
  swc_byte_t cfg_q;
  logic pwr_dn_q, tmout_q, wake, ost_busy, ost_done, ost_start;
  logic wdog_wake, wake_any, sleep_entry, asleep_nx, gen_at_wake_q;
  logic wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // bus write data, low byte
  function automatic swc_byte_t wbyte(input logic [31:0] d);
    return d[7:0];
  endfunction : wbyte
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : hit
  swc_wake_eval swc_wake_eval_inst (
    .intctl(intctl_q),
    .en_one(en_one_q),
    .en_two(en_two_q),
    .flg_one(flg_one_q),
    .flg_two(flg_two_q),
    .wake(wake)
  );
  swc_ost_timer swc_ost_timer_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(ost_start),
    .busy(ost_busy),
    .done(ost_done)
  );
  assign wdog_wake = (state_q == SWC_SLEEP) && wdog_timeout
    && cfg_q[`SWC_CFG_WDOG_EN_BIT];
  assign wake_any = wake || wdog_wake;
  // executed sleep: no enabled flag pending at the instruction
  assign sleep_entry = (state_q == SWC_RUN) && sleep_exec && !wake;
  // asleep in the next cycle
  assign asleep_nx = sleep_entry || (state_q == SWC_SLEEP && !wake_any);
  assign ost_start = (state_q == SWC_SLEEP) && wake_any
    && cfg_q[`SWC_CFG_XTAL_BIT];
  // enable registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ioc_q <= 8'h00;
      en_one_q <= 8'h00;
      en_two_q <= 8'h00;
      cfg_q <= `SWC_CFG_RST;
    end else if (wr) begin
      if (hit(paddr, `SWC_OFF_IOC)) ioc_q <= wbyte(pwdata);
      if (hit(paddr, `SWC_OFF_PEN_ONE)) en_one_q <= wbyte(pwdata);
      if (hit(paddr, `SWC_OFF_PEN_TWO)) begin
        en_two_q <= wbyte(pwdata) & `SWC_PEN_TWO_MASK;
      end
      if (hit(paddr, `SWC_OFF_CFG)) cfg_q <= wbyte(pwdata) & 8'h03;
    end
  end
  // interrupt control and flags; hardware set wins over write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      intctl_q <= 8'h00;
      flg_one_q <= 8'h00;
      flg_two_q <= 8'h00;
    end else begin
      if (wr && hit(paddr, `SWC_OFF_INTCTL)) intctl_q <= wbyte(pwdata);
      if (ext_edge_set) intctl_q[`SWC_EXT_FLAG_BIT] <= 1'b1;
      if (port_change_set) intctl_q[`SWC_PORT_FLAG_BIT] <= 1'b1;
      flg_one_q <= ((wr && hit(paddr, `SWC_OFF_PFL_ONE)) ? wbyte(pwdata)
        : flg_one_q) | flg_one_set;
      flg_two_q <= (((wr && hit(paddr, `SWC_OFF_PFL_TWO)) ? wbyte(pwdata)
        : flg_two_q) | {7'h00, flg_two_set}) & `SWC_PEN_TWO_MASK;
    end
  end
  // sleep state machine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SWC_RUN;
      gen_at_wake_q <= 1'b0;
    end else begin
      case (state_q)
        SWC_RUN: begin
          if (sleep_entry) state_q <= SWC_SLEEP;
        end
        SWC_SLEEP: begin
          if (wake_any) begin
            gen_at_wake_q <= intctl_q[`SWC_GLB_EN_BIT] && !wdog_wake;
            state_q <= cfg_q[`SWC_CFG_XTAL_BIT] ? SWC_OST : SWC_RESUME;
          end
        end
        SWC_OST: begin
          if (ost_done) state_q <= SWC_RESUME;
        end
        SWC_RESUME: state_q <= SWC_RUN;
        default: state_q <= SWC_RUN;
      endcase
    end
  end
  // status flags, power-down set at power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_dn_q <= 1'b1;
      tmout_q <= 1'b1;
    end else begin
      if (sleep_entry) begin
        pwr_dn_q <= 1'b0;
        tmout_q <= 1'b1;
      end else if (wdog_wake) begin
        tmout_q <= 1'b0;
      end else if (state_q == SWC_RUN && wdog_clr_exec) begin
        pwr_dn_q <= 1'b1;
        tmout_q <= 1'b1;
      end
    end
  end
  // core and watchdog outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdog_clear <= 1'b0;
      prefetch_req <= 1'b0;
      core_stall <= 1'b0;
      vector_req <= 1'b0;
      vector_addr <= `SWC_INT_VECTOR;
      osc_drv_en <= 1'b1;
      port_hold <= 1'b0;
    end else begin
      // clear on executed entry when the watchdog is enabled, and on every wake
      wdog_clear <= (sleep_entry && cfg_q[`SWC_CFG_WDOG_EN_BIT])
        || (state_q == SWC_SLEEP && wake_any);
      prefetch_req <= state_q == SWC_RUN && sleep_exec;
      // stall held through start-up so the core never runs early
      core_stall <= asleep_nx || ost_start
        || (state_q == SWC_OST && !ost_done);
      // vector after the following instruction runs
      vector_req <= state_q == SWC_RESUME && gen_at_wake_q;
      vector_addr <= `SWC_INT_VECTOR;
      // timer one oscillator is outside this block; driver on at wake
      osc_drv_en <= !asleep_nx;
      // ports stay frozen until the core runs again
      port_hold <= asleep_nx || ost_start
        || (state_q == SWC_OST && !ost_done);
    end
  end
  // apb read data, zero wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `SWC_OFF_STAT
        || paddr[1:0] != 2'b00);
      if (rd) begin
        case (paddr)
          `SWC_OFF_IOC: prdata <= {24'h0, ioc_q};
          `SWC_OFF_INTCTL: prdata <= {24'h0, intctl_q};
          `SWC_OFF_PEN_ONE: prdata <= {24'h0, en_one_q};
          `SWC_OFF_PEN_TWO: prdata <= {24'h0, en_two_q};
          `SWC_OFF_PFL_ONE: prdata <= {24'h0, flg_one_q};
          `SWC_OFF_PFL_TWO: prdata <= {24'h0, flg_two_q};
          `SWC_OFF_CFG: prdata <= {24'h0, cfg_q};
          `SWC_OFF_STAT: prdata <= {28'h0, ost_busy,
            state_q != SWC_RUN, tmout_q, pwr_dn_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : swc_sleep_ctrl

// ### verilog/swc_map.svh
// register offsets, field positions, reset values and timing counts
// of the sleep and wake controller; definitions only
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
// apb byte offsets
`define SWC_OFF_IOC 12'h000
`define SWC_OFF_INTCTL 12'h004
`define SWC_OFF_PEN_ONE 12'h008
`define SWC_OFF_PEN_TWO 12'h00c
`define SWC_OFF_PFL_ONE 12'h010
`define SWC_OFF_PFL_TWO 12'h014
`define SWC_OFF_CFG 12'h018
`define SWC_OFF_STAT 12'h01c
// interrupt control fields
`define SWC_GLB_EN_BIT 7
`define SWC_PERIPH_GATE_BIT 6
`define SWC_INTE_BIT 4
`define SWC_RBIE_BIT 3
`define SWC_EXT_FLAG_BIT 1
`define SWC_PORT_FLAG_BIT 0
// wake-capable bits: timer one, capture one, sync serial, receive, conversion
`define SWC_PEN_ONE_WAKE_MASK 8'h6d
`define SWC_PEN_TWO_MASK 8'h01
// config fields
`define SWC_CFG_WDOG_EN_BIT 0
`define SWC_CFG_XTAL_BIT 1
`define SWC_CFG_RST 8'h03
// status fields
`define SWC_STAT_PWRDN_BIT 0
`define SWC_STAT_TMOUT_BIT 1
`define SWC_STAT_SLEEP_BIT 2
`define SWC_STAT_OST_BIT 3
// timing: start-up time in oscillator periods, four periods per cycle
`define SWC_OST_TOSC 1024
`define SWC_TOSC_PER_CYC 4
`define SWC_OST_CYC ((`SWC_OST_TOSC + `SWC_TOSC_PER_CYC - 1) / `SWC_TOSC_PER_CYC)
`define SWC_INT_VECTOR 13'h0004
`endif

// ### verilog/swc_pkg.sv
// types of the sleep and wake controller
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_RUN = 2'b00,
    SWC_SLEEP = 2'b01,
    SWC_OST = 2'b10,
    SWC_RESUME = 2'b11
  } swc_state_e;
  typedef logic [7:0] swc_byte_t;
endpackage : swc_pkg

// ### verilog/swc_wake_eval.sv
// wake request from flags and enables; purely combinational
// assumes flags and enables arrive from registers of the top
`timescale 1ns/10ps
`include "swc_map.svh"
module swc_wake_eval
  import swc_pkg::*;
(
  // register contents
  input wire swc_byte_t intctl,
  input wire swc_byte_t en_one,
  input wire swc_byte_t en_two,
  input wire swc_byte_t flg_one,
  input wire swc_byte_t flg_two,
  // result
  output logic wake
);
  always_comb begin
    wake = 1'b0;
    // global enable ignored on purpose
    if (intctl[`SWC_INTE_BIT] && intctl[`SWC_EXT_FLAG_BIT]) begin
      wake = 1'b1;
    end
    if (intctl[`SWC_RBIE_BIT] && intctl[`SWC_PORT_FLAG_BIT]) begin
      wake = 1'b1;
    end
    if (|(en_one & flg_one & `SWC_PEN_ONE_WAKE_MASK)) begin
      wake = 1'b1;
    end
    if (|(en_two & flg_two & `SWC_PEN_TWO_MASK)) begin
      wake = 1'b1;
    end
  end
endmodule : swc_wake_eval

// ### verilog/swc_ost_timer.sv
// oscillator start-up counter; start pulse, done pulse
// assumes clk_sys keeps running for the count
`timescale 1ns/10ps
`include "swc_map.svh"
module swc_ost_timer
  import swc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [9:0] cnt_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 10'h000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= 10'((`SWC_OST_CYC) - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q == 10'h000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 10'h001;
        end
      end
    end
  end
endmodule : swc_ost_timer

// ### dv/swc_sleep_props.sv
// assertions on the sleep and wake controller ports
// assumes binding to swc_sleep_ctrl, one clock domain
`timescale 1ns/10ps
module swc_sleep_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // core and clocks
  input wire logic sleep_exec,
  input wire logic prefetch_req,
  input wire logic core_stall,
  input wire logic vector_req,
  input wire logic [12:0] vector_addr,
  input wire logic osc_drv_en,
  input wire logic port_hold
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_osc_off_stall: assert property (!osc_drv_en |-> core_stall)
    else $error("oscillator off while running");
  a_stall_entry: assert property ($rose(core_stall)
    |-> !osc_drv_en && port_hold)
    else $error("sleep entry without freeze");
  a_stall_cause: assert property ($rose(core_stall) |-> $past(sleep_exec))
    else $error("sleep without instruction");
  a_prefetch_cause: assert property (sleep_exec && !core_stall
    |=> prefetch_req)
    else $error("no prefetch on sleep");
  a_vector_fixed: assert property (vector_req |-> vector_addr == 13'h0004)
    else $error("wrong vector address");
  c_sleep: cover property ($rose(core_stall));
  c_vector: cover property (vector_req);
  c_slverr: cover property (pslverr);
endmodule : swc_sleep_props
bind swc_sleep_ctrl swc_sleep_props swc_sleep_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
  .prefetch_req(prefetch_req), .core_stall(core_stall),
  .vector_req(vector_req), .vector_addr(vector_addr),
  .osc_drv_en(osc_drv_en), .port_hold(port_hold));

// ### dv/swc_core_model.sv
// core, watchdog and interrupt pin model driving one-cycle pulses
// assumes the bench calls its tasks; one idle cycle between pulses
`timescale 1ns/10ps
module swc_core_model (
  // clock
  input wire logic clk_sys,
  // pulses to the controller
  output logic sleep_exec,
  output logic wdog_clr_exec,
  output logic wdog_timeout,
  output logic ext_edge_set
);
  logic [3:0] drv = 4'h0;
  assign {ext_edge_set, wdog_timeout, wdog_clr_exec, sleep_exec} = drv;
  // idle cycle after each pulse acts as the nop after sleep
  task automatic pulse(input int unsigned which);
    @(posedge clk_sys);
    drv <= 4'h1 << which;
    @(posedge clk_sys);
    drv <= 4'h0;
  endtask : pulse
  task automatic do_sleep(input bit pre_clr);
    if (pre_clr) pulse(1);
    pulse(0);
  endtask : do_sleep
endmodule : swc_core_model

// ### dv/sleep_wake_controller_test.sv
// self-checking bench for the sleep and wake controller
// assumes swc_sleep_ctrl, swc_core_model and the bound checker
`timescale 1ns/10ps
`include "swc_map.svh"
module sleep_wake_controller_test;
  import swc_pkg::*;
  logic clk_sys, rst_n, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, prefetch_req, core_stall, vector_req, wdog_clear;
  logic sleep_exec, wdog_clr_exec, wdog_timeout, ext_edge_set;
  logic [9:0] src_set;
  logic osc_drv_en, port_hold;
  logic [12:0] vector_addr;
  int n_fail = 0, comparisons = 0, n_vec = 0, n_wclr = 0, cyc;
  swc_sleep_ctrl swc_sleep_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .wdog_clr_exec(wdog_clr_exec),
    .prefetch_req(prefetch_req), .core_stall(core_stall),
    .vector_req(vector_req), .vector_addr(vector_addr),
    .wdog_timeout(wdog_timeout), .wdog_clear(wdog_clear),
    .flg_one_set(src_set[7:0]), .flg_two_set(src_set[8]),
    .ext_edge_set(ext_edge_set), .port_change_set(src_set[9]),
    .osc_drv_en(osc_drv_en), .port_hold(port_hold));
  swc_core_model swc_core_model_inst (.clk_sys(clk_sys),
    .sleep_exec(sleep_exec), .wdog_clr_exec(wdog_clr_exec),
    .wdog_timeout(wdog_timeout), .ext_edge_set(ext_edge_set));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (vector_req === 1'b1) n_vec++;
    if (wdog_clear === 1'b1) n_wclr++;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle pulse on the peripheral, port change and flag set inputs
  task automatic src_pulse(input logic [9:0] v);
    @(posedge clk_sys);
    src_set <= v;
    @(posedge clk_sys);
    src_set <= 10'h000;
  endtask : src_pulse
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) n_fail++;
    if (i == 20) summarize();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_wake();
    cyc = 0;
    while (core_stall !== 1'b0 && cyc < 600) begin
      @(posedge clk_sys);
      cyc++;
    end
    if (cyc == 600) n_fail++;
    if (cyc == 600) summarize();
    repeat (4) @(posedge clk_sys);
  endtask : wait_wake
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_set = 10'h000;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk(32'(osc_drv_en), 32'h1);
    apb(1'b0, `SWC_OFF_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, `SWC_OFF_CFG, 32'h0);
    chk(rd, 32'(`SWC_CFG_RST));
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, `SWC_OFF_CFG, 32'h1);
    apb(1'b1, `SWC_OFF_INTCTL, 32'h10);
    $display("test reset done");
    n_wclr = 0;
    swc_core_model_inst.do_sleep(1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'({core_stall, osc_drv_en, port_hold}), 32'h5);
    chk(32'(n_wclr), 32'h1);
    apb(1'b0, `SWC_OFF_STAT, 32'h0);
    chk(rd, 32'h6);
    swc_core_model_inst.pulse(3);
    wait_wake();
    chk(32'(cyc < 8), 32'h1);
    chk(32'(n_wclr), 32'h2);
    chk(32'(n_vec), 32'h0);
    apb(1'b0, `SWC_OFF_STAT, 32'h0);
    chk(rd, 32'h2);
    $display("test interrupt wake done");
    swc_core_model_inst.do_sleep(1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(32'(core_stall), 32'h0);
    apb(1'b0, `SWC_OFF_STAT, 32'h0);
    chk(rd, 32'h3);
    $display("test pending flag done");
    apb(1'b1, `SWC_OFF_INTCTL, 32'h90);
    swc_core_model_inst.do_sleep(1'b0);
    swc_core_model_inst.pulse(3);
    wait_wake();
    chk(32'(n_vec), 32'h1);
    $display("test vector done");
    apb(1'b1, `SWC_OFF_INTCTL, 32'h0);
    swc_core_model_inst.do_sleep(1'b0);
    swc_core_model_inst.pulse(2);
    wait_wake();
    apb(1'b0, `SWC_OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("test watchdog wake done");
    apb(1'b1, `SWC_OFF_PEN_ONE, 32'hff);
    swc_core_model_inst.do_sleep(1'b0);
    src_pulse(10'h002);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(32'(core_stall), 32'h1);
    src_pulse(10'h001);
    wait_wake();
    chk(32'(cyc < 8), 32'h1);
    apb(1'b1, `SWC_OFF_PFL_ONE, 32'h0);
    apb(1'b1, `SWC_OFF_PEN_TWO, 32'h1);
    swc_core_model_inst.do_sleep(1'b0);
    src_pulse(10'h100);
    wait_wake();
    chk(32'(cyc < 8), 32'h1);
    apb(1'b0, `SWC_OFF_PFL_TWO, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `SWC_OFF_PFL_TWO, 32'h0);
    apb(1'b1, `SWC_OFF_INTCTL, 32'h08);
    swc_core_model_inst.do_sleep(1'b0);
    src_pulse(10'h200);
    wait_wake();
    chk(32'(cyc < 8), 32'h1);
    $display("test peripheral wake done");
    apb(1'b1, `SWC_OFF_CFG, 32'h3);
    apb(1'b1, `SWC_OFF_INTCTL, 32'h10);
    swc_core_model_inst.do_sleep(1'b0);
    swc_core_model_inst.pulse(3);
    wait_wake();
    chk(32'(cyc >= `SWC_OST_CYC), 32'h1);
    apb(1'b1, `SWC_OFF_INTCTL, 32'h10);
    swc_core_model_inst.do_sleep(1'b0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'(core_stall), 32'h1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'({core_stall, osc_drv_en}), 32'h1);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, `SWC_OFF_STAT, 32'h0);
    chk(rd, 32'h3);
    $display("test crystal and master clear done");
    summarize();
  end
endmodule : sleep_wake_controller_test
